// [hw/lmc_defines.vh]
/*
 * Constants for the limiter, mix and mode control block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef LMC_DEFINES_VH
`define LMC_DEFINES_VH

// Register offsets (word addresses on the plain register port)
`define LMC_REG_LIMIT    4'h0
`define LMC_REG_MIX      4'h1
`define LMC_REG_BRIDGE   4'h2
`define LMC_REG_MODE     4'h3
`define LMC_REG_STATUS   4'h4

// Field positions in the limit register
`define LMC_ATK_LSB      0
`define LMC_REL_LSB      4
// Bridge register fields
`define LMC_HB_BIT       0
`define LMC_PCOMP_LSB    8
`define LMC_NCOMP_LSB    16
// Mode register fields
`define LMC_ALP_BIT      0
`define LMC_SPD_BIT      1
`define LMC_PWM_BIT      2

// Reset values
`define LMC_ATK_RST      3'h1
`define LMC_REL_RST      4'hA
`define LMC_MIX_RST      4'h9
`define LMC_PCOMP_RST    5'h10
`define LMC_NCOMP_RST    5'h00

// Timing: attack base 1 period, x4 per code; release base 16, x2 per code
`define LMC_ATK_BASE     20'h00001
`define LMC_REL_BASE     20'h00010
`define LMC_CNT_W        20

// Gain attenuation in 0.5 dB steps, saturating
`define LMC_GAIN_W       8
`define LMC_GAIN_MAX     8'hFF

// Mix source codes
`define LMC_SRC_MUTE     2'h0
`define LMC_SRC_RIGHT    2'h1
`define LMC_SRC_LEFT     2'h2
`define LMC_SRC_AVG      2'h3

// Sample width and FIFO depth
`define LMC_SMP_W        24
`define LMC_FIFO_DEPTH   8

`endif

// [hw/lmc_fifo.v]
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
module lmc_fifo #(
   parameter WIDTH = 48,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   // Clock and reset
   input  wire             clk_in,
   input  wire             rst_b_in,
   // Fill side
   input  wire             in_valid_in,
   output wire             in_ready_out,
   input  wire [WIDTH-1:0] in_data_in,
   // Drain side
   output wire             out_valid_out,
   input  wire             out_ready_in,
   output wire [WIDTH-1:0] out_data_out
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wr_ptr;
   reg  [AW-1:0]    rd_ptr;
   reg  [AW:0]      count;
   wire             do_wr;
   wire             do_rd;

   assign in_ready_out  = (count != DEPTH[AW:0]);
   assign out_valid_out = (count != {(AW+1){1'b0}});
   assign out_data_out  = mem[rd_ptr];
   assign do_wr = in_valid_in & in_ready_out;
   assign do_rd = out_valid_out & out_ready_in;

   always @(posedge clk_in) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // lmc_fifo

// [hw/lmc_ctrl.v]
/*
 * Limiter timing, channel mix, bridge enable, compensation and speed/PWM
 * mode control of a stereo digital amplifier.
 * Assumes: word clock arrives asynchronously on a pin; samples arrive
 * with a valid/ready handshake on clk_in; register port is synchronous.
 */
//
// Contract
// - During a clip the limiter gain drops by 0.5 dB per attack interval.
// - Attack code n gives 4 to the power n word clock periods per step.
// - Attack code resets to the value giving four periods per step.
// - Release code n gives 16 times 2 to the power n periods per step.
// - Release code resets to 1010, that is 16384 periods per step.
// - Release restores gain after the clip ends; attack reduces it.
// - Upper two mix bits pick the left output: mute, R, L or average.
// - Lower two mix bits pick the right output with the same coding.
// - Mix selector resets to 1001, left to left and right to right.
// - The bridge enable bit gates the bridge drive and resets to off.
// - Two 5-bit compensation values reset to N 00000 and P 10000.
// - Auto low power bit makes digital silence available when set.
// - Speed bit picks low or high speed; method bit picks the PWM kind.
// - Regular PWM runs 500 kHz at speed 0 and 1 MHz at speed 1.
`timescale 1ns/1ps
`include "lmc_defines.vh"
module lmc_ctrl (
   // Clock and reset
   input  wire                      clk_in,
   input  wire                      rst_b_in,
   // Register port
   input  wire [3:0]                reg_addr_in,
   input  wire [31:0]               reg_wdata_in,
   input  wire                      reg_wr_in,
   input  wire                      reg_rd_in,
   output reg  [31:0]               reg_rdata_out,
   // Word clock pin and clip indication
   input  wire                      word_clk_in,
   input  wire                      clip_in,
   // Sample stream in
   input  wire                      smp_valid_in,
   output wire                      smp_ready_out,
   input  wire [`LMC_SMP_W-1:0]     smp_left_in,
   input  wire [`LMC_SMP_W-1:0]     smp_right_in,
   // Mixed stream out
   output wire                      mix_valid_out,
   input  wire                      mix_ready_in,
   output reg  [`LMC_SMP_W-1:0]     mix_left_out,
   output reg  [`LMC_SMP_W-1:0]     mix_right_out,
   // Control outputs
   output reg  [`LMC_GAIN_W-1:0]    gain_atten_out,
   output reg                       bridge_on_out,
   output reg  [4:0]                pcomp_out,
   output reg  [4:0]                ncomp_out,
   output reg                       silence_en_out,
   output reg                       high_speed_out,
   output reg                       alt_pwm_out,
   output reg                       pwm_1mhz_out
);
   reg  [2:0]                atk_code;
   reg  [3:0]                rel_code;
   reg  [3:0]                mix_sel;
   reg                       hb_en;
   reg  [4:0]                pcomp;
   reg  [4:0]                ncomp;
   reg                       alp_en;
   reg                       spd;
   reg                       pwm_alt;
   reg  [2:0]                wck_sync;
   reg  [1:0]                clip_sync;
   reg  [`LMC_CNT_W-1:0]     per_cnt;
   reg                       clip_prev;
   wire                      wck_tick;
   wire                      clip_now;
   wire [`LMC_CNT_W-1:0]     step_len;
   wire                      fifo_in_valid;
   wire                      fifo_in_ready;
   wire [2*`LMC_SMP_W-1:0]   fifo_in_data;
   wire [2*`LMC_SMP_W-1:0]   fifo_out_data;
   wire                      out_take;
   reg  [`LMC_SMP_W-1:0]     next_left;
   reg  [`LMC_SMP_W-1:0]     next_right;
   wire                      fifo_out_valid;
   wire                      fifo_out_ready;
   reg                       out_full;

   // Picks one output source from a 2-bit code
   function [`LMC_SMP_W-1:0] pick_src;
      input [1:0]             code;
      input [`LMC_SMP_W-1:0]  l;
      input [`LMC_SMP_W-1:0]  r;
      reg   [`LMC_SMP_W:0]    sum;
      begin
         sum = {l[`LMC_SMP_W-1], l} + {r[`LMC_SMP_W-1], r};
         case (code)
            `LMC_SRC_MUTE:  pick_src = {`LMC_SMP_W{1'b0}};
            `LMC_SRC_RIGHT: pick_src = r;
            `LMC_SRC_LEFT:  pick_src = l;
            default:        pick_src = sum[`LMC_SMP_W:1];
         endcase
      end
   endfunction

   // Longest step is 2^19 periods, so 20 counter bits never overflow
   // Attack length x4 per code
   assign step_len = clip_now ?
      (`LMC_ATK_BASE << {atk_code, 1'b0}) :
      (`LMC_REL_BASE << rel_code);

   // Word clock pin: two flops before use, a third to find the edge.
   // No reset here, so the history is real after release and a pin
   // that happens to be high gives no false edge.
   always @(posedge clk_in) begin
      wck_sync <= {wck_sync[1:0], word_clk_in};
   end

   // Clip level: two flops; it idles low, so clearing it is safe
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         clip_sync <= 2'h0;
      end else begin
         clip_sync <= {clip_sync[0], clip_in};
      end
   end
   assign wck_tick = wck_sync[1] & ~wck_sync[2];
   assign clip_now = clip_sync[1];

   // Register writes
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         atk_code <= `LMC_ATK_RST;
         rel_code <= `LMC_REL_RST;
         mix_sel  <= `LMC_MIX_RST;
         hb_en    <= 1'b0;
         pcomp    <= `LMC_PCOMP_RST;
         ncomp    <= `LMC_NCOMP_RST;
         alp_en   <= 1'b0;
         spd      <= 1'b0;
         pwm_alt  <= 1'b0;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `LMC_REG_LIMIT: begin
               atk_code <= reg_wdata_in[`LMC_ATK_LSB +: 3];
               rel_code <= reg_wdata_in[`LMC_REL_LSB +: 4];
            end
            `LMC_REG_MIX: begin
               mix_sel <= reg_wdata_in[3:0];
            end
            `LMC_REG_BRIDGE: begin
               hb_en <= reg_wdata_in[`LMC_HB_BIT];
               pcomp <= reg_wdata_in[`LMC_PCOMP_LSB +: 5];
               ncomp <= reg_wdata_in[`LMC_NCOMP_LSB +: 5];
            end
            `LMC_REG_MODE: begin
               alp_en  <= reg_wdata_in[`LMC_ALP_BIT];
               spd     <= reg_wdata_in[`LMC_SPD_BIT];
               pwm_alt <= reg_wdata_in[`LMC_PWM_BIT];
            end
            default: begin
               // Status and unmapped writes are dropped
            end
         endcase
      end
   end

   // Register reads, data in the following cycle; unmapped reads zero
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         reg_rdata_out <= 32'h0;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `LMC_REG_LIMIT:
               reg_rdata_out <= {24'h0, rel_code, 1'b0, atk_code};
            `LMC_REG_MIX:
               reg_rdata_out <= {28'h0, mix_sel};
            `LMC_REG_BRIDGE:
               reg_rdata_out <= {11'h0, ncomp, 3'h0, pcomp, 7'h0, hb_en};
            `LMC_REG_MODE:
               reg_rdata_out <= {29'h0, pwm_alt, spd, alp_en};
            `LMC_REG_STATUS:
               reg_rdata_out <= {23'h0, clip_now, gain_atten_out};
            default:
               reg_rdata_out <= 32'h0;
         endcase
      end else begin
         reg_rdata_out <= 32'h0;
      end
   end

   // Gain ramp paced by word clock periods
   // Attenuation saturates at both ends so a long clip cannot wrap
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         per_cnt        <= {`LMC_CNT_W{1'b0}};
         gain_atten_out <= {`LMC_GAIN_W{1'b0}};
         clip_prev      <= 1'b0;
      end else begin
         clip_prev <= clip_now;
         // Restart the interval when the direction changes
         if (clip_now != clip_prev) begin
            per_cnt <= {`LMC_CNT_W{1'b0}};
         end else if (wck_tick) begin
            if (per_cnt + 1'b1 >= step_len) begin
               per_cnt <= {`LMC_CNT_W{1'b0}};
               if (clip_now) begin
                  if (gain_atten_out != `LMC_GAIN_MAX) begin
                     gain_atten_out <= gain_atten_out + 1'b1;
                  end
               end else if (gain_atten_out != {`LMC_GAIN_W{1'b0}}) begin
                  gain_atten_out <= gain_atten_out - 1'b1;
               end
            end else begin
               per_cnt <= per_cnt + 1'b1;
            end
         end
      end
   end

   // Mode outputs from flops
   // One cycle behind the registers, so each output changes cleanly
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         bridge_on_out  <= 1'b0;
         pcomp_out      <= `LMC_PCOMP_RST;
         ncomp_out      <= `LMC_NCOMP_RST;
         silence_en_out <= 1'b0;
         high_speed_out <= 1'b0;
         alt_pwm_out    <= 1'b0;
         pwm_1mhz_out   <= 1'b0;
      end else begin
         bridge_on_out  <= hb_en;
         pcomp_out      <= pcomp;
         ncomp_out      <= ncomp;
         silence_en_out <= alp_en;
         high_speed_out <= spd;
         alt_pwm_out    <= pwm_alt;
         pwm_1mhz_out   <= spd & ~pwm_alt;
      end
   end

   // Samples queue in the FIFO, mix applied on the way out
   // The mix code in force when a pair leaves is the one applied
   assign fifo_in_valid = smp_valid_in;
   assign smp_ready_out = fifo_in_ready;
   assign fifo_in_data  = {smp_left_in, smp_right_in};

   lmc_fifo #(
      .WIDTH (2*`LMC_SMP_W),
      .DEPTH (`LMC_FIFO_DEPTH),
      .AW    (3)
   ) u_fifo (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (fifo_in_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (fifo_in_data),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (fifo_out_ready),
      .out_data_out  (fifo_out_data)
   );

   // One-stage output register; stalls the FIFO when the sink stalls
   assign mix_valid_out  = out_full;
   assign fifo_out_ready = ~out_full | mix_ready_in;
   assign out_take       = fifo_out_valid & fifo_out_ready;

   always @* begin
      next_left  = pick_src(mix_sel[3:2], fifo_out_data[2*`LMC_SMP_W-1 -:
                            `LMC_SMP_W], fifo_out_data[`LMC_SMP_W-1:0]);
      next_right = pick_src(mix_sel[1:0], fifo_out_data[2*`LMC_SMP_W-1 -:
                            `LMC_SMP_W], fifo_out_data[`LMC_SMP_W-1:0]);
   end

   // Data flops load only on a take, so a stalled pair holds still
   always @(posedge clk_in) begin
      if (!rst_b_in) begin
         out_full      <= 1'b0;
         mix_left_out  <= {`LMC_SMP_W{1'b0}};
         mix_right_out <= {`LMC_SMP_W{1'b0}};
      end else if (out_take) begin
         out_full      <= 1'b1;
         mix_left_out  <= next_left;
         mix_right_out <= next_right;
      end else if (mix_ready_in) begin
         out_full <= 1'b0;
      end
   end
endmodule // lmc_ctrl

// [tb/lmc_ctrl_properties.sv]
/* Port checker for lmc_ctrl.
   Bound to every lmc_ctrl instance; sees only its ports. */
`timescale 1ns/1ps
module lmc_ctrl_properties (
   // Clock, reset and register port
   input wire        clk_in,
   input wire        rst_b_in,
   input wire [3:0]  reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire        reg_wr_in,
   input wire        reg_rd_in,
   input wire [31:0] reg_rdata_out,
   // Streams
   input wire        smp_valid_in,
   input wire        smp_ready_out,
   input wire        mix_valid_out,
   input wire        mix_ready_in,
   input wire [23:0] mix_left_out,
   input wire [23:0] mix_right_out,
   // Control outputs
   input wire [7:0]  gain_atten_out,
   input wire        bridge_on_out,
   input wire [4:0]  pcomp_out,
   input wire [4:0]  ncomp_out,
   input wire        silence_en_out,
   input wire        high_speed_out,
   input wire        alt_pwm_out,
   input wire        pwm_1mhz_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   rd_idle_zero_a: assert property (!$past(reg_rd_in) |->
      reg_rdata_out == 32'h0) else $error("read data not idle");
   mix_rdback_a: assert property (
      (reg_wr_in && reg_addr_in == 4'h1) ##1
      (reg_rd_in && reg_addr_in == 4'h1)
      |=> reg_rdata_out == {28'h0, $past(reg_wdata_in[3:0], 2)})
      else $error("mix readback wrong");
   rst_vals_a: assert property ($rose(rst_b_in) |->
      pcomp_out == 5'h10 && ncomp_out == 5'h00 && !bridge_on_out)
      else $error("reset values wrong");
   pwm_rate_a: assert property (
      pwm_1mhz_out == (high_speed_out && !alt_pwm_out))
      else $error("pwm rate wrong");
   bridge_follow_a: assert property (reg_wr_in && reg_addr_in == 4'h2
      |-> ##2 bridge_on_out == $past(reg_wdata_in[0], 2)
      && pcomp_out == $past(reg_wdata_in[12:8], 2))
      else $error("bridge not updated");
   mode_follow_a: assert property (reg_wr_in && reg_addr_in == 4'h3
      |-> ##2 silence_en_out == $past(reg_wdata_in[0], 2)
      && high_speed_out == $past(reg_wdata_in[1], 2)
      && alt_pwm_out == $past(reg_wdata_in[2], 2))
      else $error("mode not updated");
   gain_step_a: assert property ($changed(gain_atten_out) |->
      gain_atten_out == $past(gain_atten_out) + 8'h01
      || gain_atten_out == $past(gain_atten_out) - 8'h01)
      else $error("gain jumped");
   mix_hold_a: assert property (mix_valid_out && !mix_ready_in |=>
      mix_valid_out && $stable(mix_left_out) && $stable(mix_right_out))
      else $error("mix output dropped");
   mix_answer_a: assert property (smp_valid_in && smp_ready_out
      && !mix_valid_out |-> ##[1:4] mix_valid_out)
      else $error("mix output late");
   cover property (reg_wr_in ##1 reg_rd_in);
   cover property (smp_valid_in && !smp_ready_out);
   cover property (mix_valid_out && !mix_ready_in);
   cover property ($changed(gain_atten_out));
endmodule // lmc_ctrl_properties

bind lmc_ctrl lmc_ctrl_properties lmc_ctrl_properties_i (.*);

// [tb/lmc_audio_side.sv]
/* Word clock source and output sink facing lmc_ctrl.
   Assumes the bench drives stall_in from its clock domain. */
`timescale 1ns/1ps
module lmc_audio_side (
   // Sink control
   input  wire stall_in,
   // Link side
   output reg  word_clk_out,
   output wire mix_ready_out
);
   // Audio word clock runs free; odd start offset keeps phase unrelated
   initial begin
      word_clk_out = 1'b0;
      #37;
      forever #80 word_clk_out = ~word_clk_out;
   end
   assign mix_ready_out = !stall_in;
endmodule // lmc_audio_side

// [tb/lmc_ctrl_bench.sv]
/* Self-checking bench for lmc_ctrl.
   Assumes lmc_audio_side gives the word clock and the output stall. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
   err_total++; $display("ERROR %s exp %h got %h", n, e, g); end end
module lmc_ctrl_bench;
   reg         clk_in = 1'b0;
   reg         rst_b_in;
   reg  [3:0]  reg_addr_in;
   reg  [31:0] reg_wdata_in;
   reg         reg_wr_in, reg_rd_in, clip_in, smp_valid_in, stall;
   reg  [23:0] smp_left_in, smp_right_in;
   wire [31:0] reg_rdata_out;
   wire        word_clk, smp_ready_out, mix_valid_out, mix_ready_in;
   wire [23:0] mix_left_out, mix_right_out;
   wire [7:0]  gain_atten_out;
   wire        bridge_on_out, silence_en_out, high_speed_out, alt_pwm_out;
   wire        pwm_1mhz_out;
   wire [4:0]  pcomp_out, ncomp_out;
   integer     err_total = 0;
   integer     compares = 0;
   lmc_ctrl lmc_ctrl_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .word_clk_in(word_clk),
      .clip_in(clip_in), .smp_valid_in(smp_valid_in),
      .smp_ready_out(smp_ready_out), .smp_left_in(smp_left_in),
      .smp_right_in(smp_right_in), .mix_valid_out(mix_valid_out),
      .mix_ready_in(mix_ready_in), .mix_left_out(mix_left_out),
      .mix_right_out(mix_right_out), .gain_atten_out(gain_atten_out),
      .bridge_on_out(bridge_on_out), .pcomp_out(pcomp_out),
      .ncomp_out(ncomp_out), .silence_en_out(silence_en_out),
      .high_speed_out(high_speed_out), .alt_pwm_out(alt_pwm_out),
      .pwm_1mhz_out(pwm_1mhz_out));
   lmc_audio_side lmc_audio_side_i (.stall_in(stall),
      .word_clk_out(word_clk), .mix_ready_out(mix_ready_in));
   always #5 clk_in = ~clk_in;
   task test_done;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task timeout(input string s);
      err_total++;
      $display("ERROR %s exp 1 got 0", s);
      test_done;
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clk_in) begin
         reg_addr_in <= a;
         reg_wdata_in <= d;
         reg_wr_in <= 1'b1;
      end
      @(posedge clk_in) reg_wr_in <= 1'b0;
   endtask
   task rd(input [3:0] a, output [31:0] d);
      @(posedge clk_in) begin
         reg_addr_in <= a;
         reg_rd_in <= 1'b1;
      end
      @(posedge clk_in) reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   task settle;
      repeat (2) @(posedge clk_in);
      #1;
   endtask
   task wait_mix;
      integer n;
      for (n = 0; n < 40 && mix_valid_out !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
      if (n == 40) timeout("mix valid");
   endtask
   task wait_chg(output integer n);
      reg [7:0] g;
      g = gain_atten_out;
      for (n = 0; n < 3000 && gain_atten_out === g; n++) begin
         @(posedge clk_in);
         #1;
      end
      if (n == 3000) timeout("gain step");
   endtask
   task t_reset;
      reg [31:0] d;
      rd(4'h0, d);
      `CHK("limit", 32'hA1, d)
      `CHK("hb rst", 1'b0, bridge_on_out)
      `CHK("pcomp rst", 5'h10, pcomp_out)
      `CHK("ncomp rst", 5'h00, ncomp_out)
      rd(4'h1, d);
      `CHK("mix", 32'h9, d)
      rd(4'h2, d);
      `CHK("bridge", 32'h1000, d)
      rd(4'h3, d);
      `CHK("mode", 32'h0, d)
      rd(4'h4, d);
      `CHK("status", 32'h0, d)
      rd(4'h5, d);
      `CHK("unmapped", 32'h0, d)
   endtask
   task t_mix;
      integer c;
      reg signed [24:0] s;
      reg [23:0] v [0:3];
      s = $signed({smp_left_in[23], smp_left_in})
         + $signed({smp_right_in[23], smp_right_in});
      v[0] = 24'h0;
      v[1] = smp_right_in;
      v[2] = smp_left_in;
      v[3] = s[24:1];
      for (c = 0; c < 16; c++) begin
         wr(4'h1, c);
         @(posedge clk_in) smp_valid_in <= 1'b1;
         @(posedge clk_in) smp_valid_in <= 1'b0;
         wait_mix;
         `CHK("mix l", v[c[3:2]], mix_left_out)
         `CHK("mix r", v[c[1:0]], mix_right_out)
      end
      @(posedge clk_in) begin
         reg_addr_in <= 4'h1;
         reg_wdata_in <= 32'h6;
         reg_wr_in <= 1'b1;
      end
      @(posedge clk_in) begin
         reg_wr_in <= 1'b0;
         reg_rd_in <= 1'b1;
      end
      @(posedge clk_in) reg_rd_in <= 1'b0;
      #1 `CHK("mix back", 32'h6, reg_rdata_out)
   endtask
   task t_mode;
      integer m;
      // Compensation first; the bridge stays off until the load is safe
      wr(4'h2, 32'h00080800);
      settle;
      `CHK("hb off", 1'b0, bridge_on_out)
      `CHK("pcomp", 5'h08, pcomp_out)
      `CHK("ncomp", 5'h08, ncomp_out)
      wr(4'h2, 32'h00080801);
      settle;
      `CHK("hb", 1'b1, bridge_on_out)
      for (m = 0; m < 8; m++) begin
         wr(4'h3, m);
         settle;
         `CHK("alp", m[0], silence_en_out)
         `CHK("spd", m[1], high_speed_out)
         `CHK("pwm", m[2], alt_pwm_out)
         `CHK("1mhz", m[1] & ~m[2], pwm_1mhz_out)
      end
      wr(4'h3, 32'h4);
   endtask
   task t_fifo;
      integer i, n, m;
      n = 0;
      m = 0;
      @(posedge clk_in) begin
         stall <= 1'b1;
         smp_valid_in <= 1'b1;
      end
      for (i = 0; i < 20; i++) begin
         @(negedge clk_in);
         if (smp_ready_out === 1'b1) n++;
      end
      @(posedge clk_in) begin
         stall <= 1'b0;
         smp_valid_in <= 1'b0;
      end
      for (i = 0; i < 30; i++) begin
         @(negedge clk_in);
         if ((mix_valid_out & mix_ready_in) === 1'b1) m++;
      end
      // Eight queued pairs plus the one held in the output flops
      `CHK("fill", 9, n)
      `CHK("drain", n, m)
   endtask
   task t_limiter;
      integer n;
      integer i;
      reg [7:0] g;
      wr(4'h0, 32'h0);
      @(posedge clk_in) clip_in <= 1'b1;
      wait_chg(n);
      wait_chg(n);
      // One word clock period is 16 clock cycles in this bench
      `CHK("atk0", 16, n)
      wr(4'h0, 32'h1);
      wait_chg(n);
      wait_chg(n);
      `CHK("atk1", 64, n)
      @(posedge clk_in) clip_in <= 1'b0;
      wait_chg(n);
      g = gain_atten_out;
      wait_chg(n);
      `CHK("rel0", 256, n)
      `CHK("rel dn", g - 8'h01, gain_atten_out)
      for (i = 0; i < 40 && gain_atten_out !== 8'h00; i++) wait_chg(n);
      // Longer than one release step, so the floor must hold
      repeat (300) @(posedge clk_in);
      #1;
      `CHK("floor", 8'h00, gain_atten_out)
   endtask
   initial begin
      rst_b_in = 1'b0;
      reg_addr_in = 4'h0;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      clip_in = 1'b0;
      smp_valid_in = 1'b0;
      stall = 1'b0;
      smp_left_in = 24'h000005;
      smp_right_in = 24'hFFFFF8;
      repeat (20) @(posedge clk_in);
      rst_b_in <= 1'b1;
      t_reset;
      t_mix;
      t_mode;
      t_fifo;
      t_limiter;
      test_done;
   end
endmodule // lmc_ctrl_bench
